// ===== logic/wakeup_cyclic_sense_ctrl.sv
// Wake-up and cyclic sense controller of the companion die
//
// Overview of operation
// - Stop wake raises interrupt, enters Normal.
// - Sleep wake enters Reset mode.
// - New Stop only after wake-source read.
// - Without cyclic sense, enabled input change wakes.
// - Wake-enabled inputs lose analog function in low power.
// - Cyclic sense compares samples between events.
// - Stop uses trimmed tick, Sleep untrimmed.
// - Low power cyclic sense overrides high-side control.
// - Simultaneous forced and input wake reports forced.
// - Nonzero multiplier enables periodic forced wake.
// - Bus wake needs long dominant then recessive.
// - Normal request wakes Stop, sets no flag.
// - Low voltage or external reset in Stop: Reset, flagged.
// - Sleep supply loss enters Power On.
// - Select field decodes off, one, two, both.
// - No enables: outputs still switch, no detection.
// - Wake control bits 5..0 enable inputs.
// - Wake-source layout; read clears, writes ignored.
// - Multiplier code gives power-of-two period multiple.
// - Reset status read clears, writes ignored.
`timescale 1ns/1ps
`include "wakeup_params.svh"

module wakeup_cyclic_sense_ctrl
(
    input  wire logic       clk_sys,        // System clock
    input  wire logic       rst_n,          // Asynchronous reset
    input  wire logic       regWrite,       // Die link write strobe
    input  wire logic       regRead,        // Die link read strobe
    input  wire logic [7:0] regAddr,        // Register offset
    input  wire logic [7:0] regWdata,       // Write data
    output logic      [7:0] regRdata,       // Read data
    input  wire logic       tickTrimmed,    // 1 ms pulse, trimmed base clock
    input  wire logic       tickRaw,        // 1 ms pulse, untrimmed base clock
    input  wire logic [5:0] wakeIn,         // Wake input levels
    input  wire logic       busDominant,    // Bus is dominant
    input  wire logic       coreLowVoltage, // Core supply low
    input  wire logic       extResetEvent,  // External reset pin event
    input  wire logic       mainSupplyLow,  // Main supply below power-on level
    input  wire logic       resetRelease,   // Reset sequence finished
    input  wire logic       hsCtrlOne,      // Normal control of output one
    input  wire logic       hsCtrlTwo,      // Normal control of output two
    output logic            highSideOne,    // High-side output one
    output logic            highSideTwo,    // High-side output two
    output logic      [5:0] analogDisable,  // Analog input disables
    output logic            dieLinkIrq,     // Die-link interrupt pulse
    output logic      [2:0] modeOut         // Current mode
);

    wakeup_pkg::state_t st;       // Registered state
    wakeup_pkg::state_t next_st;  // Next state

    logic       lowPower;     // Stop or Sleep
    logic       cyclicOn;     // Cyclic sense selected
    logic       msTick;       // Selected base tick
    logic       csEvent;      // Cyclic sense event
    logic       forcedWake;   // Forced wake this cycle
    logic [5:0] inChange;     // Enabled input changes
    logic       busWake;      // Bus wake this cycle
    logic       wakeAny;      // Any flagged wake
    logic       readWsr;      // Wake-source read
    logic       readRsr;      // Reset status read
    logic [9:0] periodMs;     // Cyclic period in ms
    logic [10:0] fwMult;      // Forced multiplier

    // Cyclic sense period per code
    function automatic logic [9:0] cst_ms(input logic [3:0] code);
        unique case (code)
            4'h0: cst_ms = 10'h001;
            4'h1: cst_ms = 10'h002;
            4'h2: cst_ms = 10'h005;
            4'h3: cst_ms = 10'h00a;
            4'h4: cst_ms = 10'h014;
            4'h5: cst_ms = 10'h032;
            4'h6: cst_ms = 10'h064;
            4'h7: cst_ms = 10'h0c8;
            4'h8: cst_ms = 10'h1f4;
            default: cst_ms = 10'h3e8;
        endcase
    endfunction : cst_ms

    // Derived control terms
    always_comb
    begin
        lowPower = (st.mode == wakeup_pkg::STOP) || (st.mode == wakeup_pkg::SLEEP);
        cyclicOn = st.wake_control[`WCS_CYCLIC_SENSE_SELECT_MSB:`WCS_CYCLIC_SENSE_SELECT_LSB] != 2'b00;
        msTick = (st.mode == wakeup_pkg::STOP) ? tickTrimmed : tickRaw;
        periodMs = cst_ms(st.timing_control_reg[`WCS_CST_MSB:`WCS_CST_LSB]);
        // Codes above eleven behave as the largest multiplier
        if (st.timing_control_reg[`WCS_FWM_MSB:`WCS_FWM_LSB] >= 4'hb)
        begin
            fwMult = 11'h400;
        end
        else
        begin
            fwMult = 11'h001 << (st.timing_control_reg[`WCS_FWM_MSB:`WCS_FWM_LSB] - 4'h1);
        end
        csEvent = lowPower && msTick && (st.msCount + 10'h001 >= periodMs)
                  && (cyclicOn || st.timing_control_reg[`WCS_FWM_MSB:`WCS_FWM_LSB] != 4'h0);
        forcedWake = csEvent && st.timing_control_reg[`WCS_FWM_MSB:`WCS_FWM_LSB] != 4'h0
                     && (st.fwCount + 11'h001 >= fwMult);
        // Change against reference, sampled at the end of the on time when cyclic
        if (cyclicOn)
        begin
            inChange = (st.hsTimer == 4'h1) ? ((st.syncB ^ st.refLevel) & st.wake_control[5:0]) : 6'h00;
        end
        else
        begin
            inChange = (st.syncB ^ st.refLevel) & st.wake_control[5:0];
        end
        if (!lowPower)
        begin
            inChange = 6'h00;
        end
        busWake = lowPower && !busDominant
                  && (st.busCount >= 11'(`WCS_BUS_FILTER_CYC));
        wakeAny = forcedWake || (inChange != 6'h00) || busWake;
        readWsr = regRead && (regAddr == `WCS_OFF_WAKE_SRC);
        readRsr = regRead && (regAddr == `WCS_OFF_RST_STAT);
    end

    // Next-state logic
    always_comb
    begin
        next_st = st;
        next_st.irq = 1'b0;
        next_st.syncA = wakeIn;
        next_st.syncB = st.syncA;
        // Register writes; status registers ignore writes
        if (regWrite && regAddr == `WCS_OFF_WAKE_CTRL)
        begin
            next_st.wake_control = regWdata;
        end
        if (regWrite && regAddr == `WCS_OFF_TIMING)
        begin
            next_st.timing_control_reg = regWdata;
        end
        // Register reads
        unique case (regAddr)
            `WCS_OFF_WAKE_CTRL: next_st.rdata = st.wake_control;
            `WCS_OFF_TIMING:    next_st.rdata = st.timing_control_reg;
            `WCS_OFF_WAKE_SRC:  next_st.rdata = st.wake_source_reg;
            `WCS_OFF_RST_STAT:  next_st.rdata = st.rsr;
            `WCS_OFF_MODE:      next_st.rdata = {5'h00, st.mode};
            default:            next_st.rdata = 8'h00;
        endcase
        if (!regRead)
        begin
            next_st.rdata = st.rdata;
        end
        // Read clears; a new set in the same cycle wins
        if (readWsr)
        begin
            next_st.wake_source_reg = 8'h00;
            next_st.stopArmed = 1'b1;
        end
        if (readRsr)
        begin
            next_st.rsr = 8'h00;
        end
        // Cyclic timing and on-time of the high-side outputs
        if (st.hsTimer != 4'h0)
        begin
            next_st.hsTimer = st.hsTimer - 4'h1;
        end
        if (st.hsTimer == 4'h1)
        begin
            next_st.refLevel = st.syncB;
        end
        if (csEvent)
        begin
            next_st.msCount = 10'h000;
            next_st.hsTimer = cyclicOn ? `WCS_HS_ON_CYC : 4'h0;
            next_st.fwCount = forcedWake ? 11'h000 : st.fwCount + 11'h001;
        end
        else if (lowPower && msTick)
        begin
            next_st.msCount = st.msCount + 10'h001;
        end
        // Dominant duration on the bus
        if (lowPower && busDominant)
        begin
            next_st.busCount = (st.busCount == 11'h7ff) ? st.busCount : st.busCount + 11'h001;
        end
        else
        begin
            next_st.busCount = 11'h000;
        end
        // Wake-source capture, held until read
        if (forcedWake)
        begin
            next_st.wake_source_reg[`WCS_SRC_FORCED] = 1'b1;
        end
        else
        begin
            next_st.wake_source_reg[5:0] = next_st.wake_source_reg[5:0] | inChange;
        end
        if (busWake)
        begin
            next_st.wake_source_reg[`WCS_SRC_BUS] = 1'b1;
        end
        // Mode sequencing
        unique case (st.mode)
            wakeup_pkg::NORMAL:
            begin
                if (regWrite && regAddr == `WCS_OFF_MODE && regWdata[1:0] == 2'b01 && st.stopArmed)
                begin
                    next_st.mode = wakeup_pkg::STOP;
                end
                else if (regWrite && regAddr == `WCS_OFF_MODE && regWdata[1:0] == 2'b10)
                begin
                    next_st.mode = wakeup_pkg::SLEEP;
                end
            end
            wakeup_pkg::STOP:
            begin
                if (coreLowVoltage || extResetEvent)
                begin
                    next_st.mode = wakeup_pkg::RESET;
                    next_st.rsr[`WCS_RST_LVR] = st.rsr[`WCS_RST_LVR] | coreLowVoltage;
                    next_st.rsr[`WCS_RST_EXR] = st.rsr[`WCS_RST_EXR] | extResetEvent;
                end
                else if (wakeAny || (regWrite && regAddr == `WCS_OFF_MODE && regWdata[1:0] == 2'b00))
                begin
                    next_st.mode = wakeup_pkg::NORMAL;
                    next_st.irq = 1'b1;
                    next_st.stopArmed = 1'b0;
                end
            end
            wakeup_pkg::SLEEP:
            begin
                if (mainSupplyLow)
                begin
                    next_st.mode = wakeup_pkg::POWERON;
                    next_st.rsr[`WCS_RST_POR] = 1'b1;
                end
                else if (wakeAny)
                begin
                    next_st.mode = wakeup_pkg::RESET;
                    next_st.rsr[`WCS_RST_WUR] = 1'b1;
                    next_st.stopArmed = 1'b0;
                end
            end
            wakeup_pkg::POWERON:
            begin
                if (!mainSupplyLow)
                begin
                    next_st.mode = wakeup_pkg::RESET;
                end
            end
            wakeup_pkg::RESET:
            begin
                // Control registers go to defaults; status is kept
                next_st.wake_control = `WCS_RESET_REG;
                next_st.timing_control_reg = `WCS_RESET_REG;
                if (resetRelease)
                begin
                    next_st.mode = wakeup_pkg::NORMAL;
                end
            end
            default:
            begin
                next_st.mode = wakeup_pkg::RESET;
            end
        endcase
        // Fresh reference and counters on low-power entry
        if (!lowPower && (next_st.mode == wakeup_pkg::STOP || next_st.mode == wakeup_pkg::SLEEP))
        begin
            next_st.refLevel = st.syncB;
            next_st.msCount = 10'h000;
            next_st.fwCount = 11'h000;
            next_st.hsTimer = 4'h0;
        end
        // High-side outputs: cyclic pattern overrides normal control
        if (lowPower && cyclicOn)
        begin
            next_st.hsOne = (next_st.hsTimer != 4'h0) && st.wake_control[6];
            next_st.hsTwo = (next_st.hsTimer != 4'h0) && st.wake_control[7];
        end
        else
        begin
            next_st.hsOne = hsCtrlOne;
            next_st.hsTwo = hsCtrlTwo;
        end
        next_st.anaDis = lowPower ? st.wake_control[5:0] : 6'h00;
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '0;
            st.stopArmed <= 1'b1;
            st.rsr <= 8'h01;
        end
        else
        begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign regRdata = st.rdata;
    assign highSideOne = st.hsOne;
    assign highSideTwo = st.hsTwo;
    assign analogDisable = st.anaDis;
    assign dieLinkIrq = st.irq;
    assign modeOut = st.mode;

    // Checks
    a_stop_wake_irq: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st.mode == wakeup_pkg::STOP ##1 st.mode == wakeup_pkg::NORMAL) |-> st.irq)
        else $error("stop wake without interrupt");
    a_sleep_exit: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st.mode == wakeup_pkg::SLEEP ##1 st.mode != wakeup_pkg::SLEEP)
        |-> (st.mode == wakeup_pkg::RESET || st.mode == wakeup_pkg::POWERON))
        else $error("sleep left to a wrong mode");
    a_stop_blocked: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (regWrite && regAddr == `WCS_OFF_MODE && !st.stopArmed && st.mode == wakeup_pkg::NORMAL)
        |=> st.mode != wakeup_pkg::STOP)
        else $error("stop taken before wake-source read");
    a_src_read_arms: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (readWsr && st.mode == wakeup_pkg::NORMAL) |=> st.stopArmed)
        else $error("wake-source read did not arm stop");
    a_forced_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(st.wake_source_reg[`WCS_SRC_FORCED]) |-> ((st.wake_source_reg[5:0] & ~$past(st.wake_source_reg[5:0])) == 6'h00))
        else $error("input flag set with forced wake");
    a_analog_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (lowPower ##1 lowPower) |-> st.anaDis == $past(st.wake_control[5:0]))
        else $error("analog disable wrong in low power");
    a_hs_override: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (lowPower && cyclicOn && st.hsTimer == 4'h0 && !csEvent && !regWrite) |=> !st.hsOne && !st.hsTwo)
        else $error("high side on outside cyclic on time");
    a_bus_stuck: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(st.wake_source_reg[`WCS_SRC_BUS]) |-> !$past(busDominant) && $past(st.busCount) >= 11'(`WCS_BUS_FILTER_CYC))
        else $error("bus wake without long dominant pulse");
    a_supply_loss: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (st.mode == wakeup_pkg::SLEEP && mainSupplyLow) |=> st.mode == wakeup_pkg::POWERON)
        else $error("sleep supply loss not handled");

endmodule : wakeup_cyclic_sense_ctrl

// ===== logic/wakeup_params.svh
// Offsets, field positions, reset values and timing counts of the wake-up controller
`ifndef WAKEUP_PARAMS_SVH
`define WAKEUP_PARAMS_SVH
`define WCS_OFF_MODE        8'h11   // Mode control register
`define WCS_OFF_WAKE_CTRL   8'h12   // Wake control register
`define WCS_OFF_TIMING      8'h13   // Timing control register
`define WCS_OFF_WAKE_SRC    8'h14   // Wake-source register
`define WCS_OFF_RST_STAT    8'h15   // Reset status register
`define WCS_CYCLIC_SENSE_SELECT_MSB       7       // Cyclic sense select field
`define WCS_CYCLIC_SENSE_SELECT_LSB       6
`define WCS_FWM_MSB         7       // Forced wake multiplier field
`define WCS_FWM_LSB         4
`define WCS_CST_MSB         3       // Cyclic sense period field
`define WCS_CST_LSB         0
`define WCS_SRC_FORCED      7       // Forced wake flag
`define WCS_SRC_BUS         6       // Bus wake flag
`define WCS_RST_POR         0       // Reset status bits
`define WCS_RST_LVR         1
`define WCS_RST_WUR         3
`define WCS_RST_EXR         4
`define WCS_RESET_REG       8'h00   // Reset value of control registers
`define WCS_CLK_PERIOD_NS   25      // System clock period
`define WCS_BUS_FILTER_NS   30000   // Bus wake filter time
`define WCS_BUS_FILTER_CYC  ((`WCS_BUS_FILTER_NS + `WCS_CLK_PERIOD_NS - 1) / `WCS_CLK_PERIOD_NS)
`define WCS_HS_ON_CYC       4'h8    // High-side on time per cyclic event
`endif

// ===== logic/wakeup_pkg.sv
// Types of the wake-up controller
package wakeup_pkg;
    // Operating modes
    typedef enum logic [2:0]
    {
        NORMAL  = 3'b000,
        STOP    = 3'b001,
        SLEEP   = 3'b010,
        RESET   = 3'b011,
        POWERON = 3'b100
    } mode_t;

    // Whole state of the controller
    typedef struct packed
    {
        mode_t       mode;       // Current mode
        logic [7:0]  wake_control;        // Wake control
        logic [7:0]  timing_control_reg;        // Timing control
        logic [7:0]  wake_source_reg;        // Wake-source flags
        logic [7:0]  rsr;        // Reset status flags
        logic        stopArmed;  // Stop command allowed
        logic [5:0]  syncA;      // First synchroniser stage
        logic [5:0]  syncB;      // Second synchroniser stage
        logic [5:0]  refLevel;   // Reference input level
        logic [9:0]  msCount;    // Cyclic period counter
        logic [3:0]  hsTimer;    // High-side on time
        logic [10:0] fwCount;    // Forced wake event count
        logic [10:0] busCount;   // Dominant duration
        logic        hsOne;      // High-side output one
        logic        hsTwo;      // High-side output two
        logic [5:0]  anaDis;     // Analog input disables
        logic        irq;        // Die-link interrupt
        logic [7:0]  rdata;      // Read data
    } state_t;
endpackage : wakeup_pkg

// ===== verification/host_link_model.sv
// Host microcontroller model that drives the die-link register strobes
`timescale 1ns/1ps
`include "wakeup_params.svh"

module host_link_model
#(
    parameter int GAP_CYC = 4              // Stands in for two base clock cycles
)
(
    input  wire logic       clk_sys,       // System clock
    output logic            regWrite,      // Write strobe
    output logic            regRead,       // Read strobe
    output logic      [7:0] regAddr,       // Register offset
    output logic      [7:0] regWdata,      // Write data
    input  wire logic [7:0] regRdata       // Read data
);
    // Idle bus at time zero
    initial
    begin
        regWrite = 1'b0;
        regRead  = 1'b0;
        regAddr  = 8'h00;
        regWdata = 8'h00;
    end

    // One-cycle write strobe, address and data held with it
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_sys);
        regWrite <= 1'b1;
        regAddr  <= addr;
        regWdata <= data;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask : write_reg

    // One-cycle read strobe, data taken once registered
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clk_sys);
        regRead <= 1'b1;
        regAddr <= addr;
        @(posedge clk_sys);
        regRead <= 1'b0;
        @(posedge clk_sys);
        #1 data = regRdata;
        // Spacing before any mode write follows
        if (addr === `WCS_OFF_WAKE_SRC)
            repeat (GAP_CYC) @(posedge clk_sys);
    endtask : read_reg
endmodule : host_link_model

// ===== verification/wakeup_cyclic_sense_ctrl_tb.sv
// Self-checking testbench of the wake-up and cyclic sense controller
`timescale 1ns/1ps
`include "wakeup_params.svh"

module wakeup_cyclic_sense_ctrl_tb;
    logic       clk_sys, rst_n, regWrite, regRead;   // Clock, reset, strobes
    logic [7:0] regAddr, regWdata, regRdata, rd;     // Register bus, read result
    logic       tickTrimmed, tickRaw, busDominant;   // Ticks and bus level
    logic       coreLowVoltage, extResetEvent;       // Reset causes
    logic       mainSupplyLow, resetRelease;         // Supply loss, reset end
    logic       hsCtrlOne, hsCtrlTwo, highSideOne, highSideTwo; // High-side
    logic [5:0] wakeIn, analogDisable;               // Wake inputs, disables
    logic       dieLinkIrq;                          // Interrupt pulse
    logic [2:0] modeOut;                             // Current mode
    logic [7:0] irqCount, c1, c2, i0;                // Pulse counters
    int         num_errors, checks;                  // Report counters

    // Clock: 25 ns period
    initial
    begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Counts interrupt pulses
    always @(posedge clk_sys) if (dieLinkIrq === 1'b1) irqCount <= irqCount + 8'h01;

    host_link_model host_u (.clk_sys(clk_sys), .regWrite(regWrite), .regRead(regRead),
        .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata));

    wakeup_cyclic_sense_ctrl dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .tickTrimmed(tickTrimmed), .tickRaw(tickRaw), .wakeIn(wakeIn), .busDominant(busDominant),
        .coreLowVoltage(coreLowVoltage), .extResetEvent(extResetEvent),
        .mainSupplyLow(mainSupplyLow), .resetRelease(resetRelease), .hsCtrlOne(hsCtrlOne),
        .hsCtrlTwo(hsCtrlTwo), .highSideOne(highSideOne), .highSideTwo(highSideTwo),
        .analogDisable(analogDisable), .dieLinkIrq(dieLinkIrq), .modeOut(modeOut));

    // Verdict and end of run
    task automatic final_report;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report

    // Compares one byte result
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    // Reads a register and compares it
    task automatic rd_check(input logic [7:0] addr, input logic [7:0] exp);
        host_u.read_reg(addr, rd);
        check(rd, exp);
    endtask : rd_check

    // Bounded wait for a mode
    task automatic wait_mode(input logic [2:0] exp, input int bound);
        int n;
        n = 0;
        while (modeOut !== exp && n < bound)
        begin
            @(posedge clk_sys);
            #1 n++;
        end
        check({5'h00, modeOut}, {5'h00, exp});
        if (modeOut !== exp)
            final_report();
    endtask : wait_mode

    // Arms and enters a low-power mode
    task automatic enter_low(input logic [7:0] m, input logic [2:0] exp);
        host_u.read_reg(`WCS_OFF_WAKE_SRC, rd);
        host_u.write_reg(`WCS_OFF_MODE, m);
        wait_mode(exp, 10);
    endtask : enter_low

    // One-cycle pulse on a tick or release input
    task automatic pulse(input int which);
        @(posedge clk_sys);
        if (which == 0) tickTrimmed <= 1'b1;
        else if (which == 1) tickRaw <= 1'b1;
        else resetRelease <= 1'b1;
        @(posedge clk_sys);
        tickTrimmed  <= 1'b0;
        tickRaw      <= 1'b0;
        resetRelease <= 1'b0;
    endtask : pulse

    // Counts high-side on cycles over a window
    task automatic count_hs;
        c1 = 8'h00;
        c2 = 8'h00;
        repeat (14)
        begin
            // Sample first so the on cycle launched by the tick is counted
            #1 c1 = c1 + {7'h00, highSideOne};
            c2 = c2 + {7'h00, highSideTwo};
            @(posedge clk_sys);
        end
    endtask : count_hs

    // Flips one wake input
    task automatic flip(input logic [5:0] m);
        @(posedge clk_sys);
        wakeIn <= wakeIn ^ m;
    endtask : flip

    // Holds reset for 12 cycles
    task automatic do_reset;
        rst_n <= 1'b0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
    endtask : do_reset

    // Reset values and read-clear status
    task automatic t_reset;
        rd_check(`WCS_OFF_RST_STAT, 8'h01);
        rd_check(`WCS_OFF_RST_STAT, 8'h00);
        host_u.write_reg(`WCS_OFF_WAKE_SRC, 8'hff);
        rd_check(`WCS_OFF_WAKE_SRC, 8'h00);
        rd_check(`WCS_OFF_WAKE_CTRL, `WCS_RESET_REG);
        $display("t_reset done");
    endtask : t_reset

    // Input wake from Stop, arming and Normal request
    task automatic t_input_stop;
        host_u.write_reg(`WCS_OFF_WAKE_CTRL, 8'h01);
        host_u.write_reg(`WCS_OFF_TIMING, 8'h00);
        enter_low(8'h01, wakeup_pkg::STOP);
        repeat (3) @(posedge clk_sys);
        check({2'b00, analogDisable}, 8'h01);
        flip(6'h02);
        repeat (20) @(posedge clk_sys);
        check({5'h00, modeOut}, 8'h01);
        i0 = irqCount;
        flip(6'h01);
        wait_mode(wakeup_pkg::NORMAL, 50);
        repeat (2) @(posedge clk_sys);
        check(irqCount - i0, 8'h01);
        host_u.write_reg(`WCS_OFF_MODE, 8'h01);
        repeat (5) @(posedge clk_sys);
        check({5'h00, modeOut}, 8'h00);
        rd_check(`WCS_OFF_WAKE_SRC, 8'h01);
        rd_check(`WCS_OFF_WAKE_SRC, 8'h00);
        host_u.write_reg(`WCS_OFF_MODE, 8'h01);
        wait_mode(wakeup_pkg::STOP, 10);
        host_u.write_reg(`WCS_OFF_MODE, 8'h00);
        wait_mode(wakeup_pkg::NORMAL, 10);
        rd_check(`WCS_OFF_WAKE_SRC, 8'h00);
        $display("t_input_stop done");
    endtask : t_input_stop

    // Sleep wake and reset causes in Stop
    task automatic t_reset_src;
        host_u.write_reg(`WCS_OFF_WAKE_CTRL, 8'h01);
        enter_low(8'h02, wakeup_pkg::SLEEP);
        flip(6'h01);
        wait_mode(wakeup_pkg::RESET, 50);
        pulse(2);
        wait_mode(wakeup_pkg::NORMAL, 20);
        rd_check(`WCS_OFF_RST_STAT, 8'h08);
        for (int k = 0; k < 2; k++)
        begin
            enter_low(8'h01, wakeup_pkg::STOP);
            @(posedge clk_sys);
            if (k == 0) coreLowVoltage <= 1'b1;
            else extResetEvent <= 1'b1;
            wait_mode(wakeup_pkg::RESET, 10);
            coreLowVoltage <= 1'b0;
            extResetEvent  <= 1'b0;
            pulse(2);
            wait_mode(wakeup_pkg::NORMAL, 20);
            rd_check(`WCS_OFF_RST_STAT, (k == 0) ? 8'h02 : 8'h10);
        end
        $display("t_reset_src done");
    endtask : t_reset_src

    // Bus wake needs a long dominant pulse then recessive
    task automatic t_bus;
        host_u.write_reg(`WCS_OFF_WAKE_CTRL, 8'h00);
        enter_low(8'h01, wakeup_pkg::STOP);
        busDominant <= 1'b1;
        repeat (100) @(posedge clk_sys);
        busDominant <= 1'b0;
        repeat (20) @(posedge clk_sys);
        check({5'h00, modeOut}, 8'h01);
        busDominant <= 1'b1;
        repeat (1300) @(posedge clk_sys);
        check({5'h00, modeOut}, 8'h01);
        busDominant <= 1'b0;
        wait_mode(wakeup_pkg::NORMAL, 10);
        rd_check(`WCS_OFF_WAKE_SRC, 8'h40);
        $display("t_bus done");
    endtask : t_bus

    // Select codes one to three, trimmed against untrimmed tick in Stop
    task automatic t_cyclic;
        hsCtrlOne <= 1'b1;
        hsCtrlTwo <= 1'b1;
        for (int s = 1; s < 4; s++)
        begin
            host_u.write_reg(`WCS_OFF_WAKE_CTRL, 8'(s << 6));
            enter_low(8'h01, wakeup_pkg::STOP);
            pulse(1);
            count_hs();
            check({c2[3:0], c1[3:0]}, 8'h00);
            pulse(0);
            count_hs();
            check(c1, s[0] ? 8'h08 : 8'h00);
            check(c2, s[1] ? 8'h08 : 8'h00);
            check({5'h00, modeOut}, 8'h01);
            host_u.write_reg(`WCS_OFF_MODE, 8'h00);
            wait_mode(wakeup_pkg::NORMAL, 10);
        end
        $display("t_cyclic done");
    endtask : t_cyclic

    // Cyclic input detection and forced wake priority
    task automatic t_forced;
        for (int f = 0; f < 2; f++)
        begin
            // Second pass: continuous sensing so the input change meets the forced event
            host_u.write_reg(`WCS_OFF_WAKE_CTRL, f ? 8'h01 : 8'h41);
            host_u.write_reg(`WCS_OFF_TIMING, f ? 8'h20 : 8'h00);
            enter_low(8'h01, wakeup_pkg::STOP);
            pulse(0);
            repeat (14) @(posedge clk_sys);
            if (f == 0) flip(6'h01);
            repeat (20) @(posedge clk_sys);
            check({5'h00, modeOut}, 8'h01);
            // Synchronised change lands on the forced tick edge
            if (f == 1)
            begin
                flip(6'h01);
                @(posedge clk_sys);
            end
            pulse(0);
            wait_mode(wakeup_pkg::NORMAL, 40);
            rd_check(`WCS_OFF_WAKE_SRC, f ? 8'h80 : 8'h01);
        end
        $display("t_forced done");
    endtask : t_forced

    // Supply loss in Sleep
    task automatic t_poweron;
        enter_low(8'h02, wakeup_pkg::SLEEP);
        mainSupplyLow <= 1'b1;
        wait_mode(wakeup_pkg::POWERON, 10);
        mainSupplyLow <= 1'b0;
        do_reset();
        $display("t_poweron done");
    endtask : t_poweron

    // Main sequence
    initial
    begin
        {tickTrimmed, tickRaw, busDominant, coreLowVoltage, extResetEvent} = 5'h00;
        {mainSupplyLow, resetRelease, hsCtrlOne, hsCtrlTwo} = 4'h0;
        wakeIn     = 6'h00;
        irqCount   = 8'h00;
        num_errors = 0;
        checks     = 0;
        rst_n      = 1'b0;
        do_reset();
        t_reset();
        t_input_stop();
        t_reset_src();
        t_bus();
        t_cyclic();
        t_forced();
        t_poweron();
        final_report();
    end
endmodule : wakeup_cyclic_sense_ctrl_tb
